// File: design/rlpr_defines.svh
// Register map, field positions, reset values and timing figures of the link controller
`ifndef RLPR_DEFINES_SVH
`define RLPR_DEFINES_SVH

`define RLPR_OFF_CTRL      8'h00
`define RLPR_OFF_NET       8'h04
`define RLPR_OFF_PORT      8'h08
`define RLPR_OFF_SELF      8'h0C
`define RLPR_OFF_STAT      8'h10
`define RLPR_OFF_TXD       8'h14
`define RLPR_OFF_LVL       8'h18

`define RLPR_PMODE_LSB     0
`define RLPR_PROTO_LSB     2
`define RLPR_RETRY_LSB     4
`define RLPR_TXPWR_LSB     6
`define RLPR_IFACE_LSB     9
`define RLPR_NETID_LSB     0
`define RLPR_HOP_LSB       16
`define RLPR_SDADDR_LSB    0
`define RLPR_BAUD_LSB      4

`define RLPR_CTRL_RST      32'h0000_0500
`define RLPR_NET_RST       32'h0000_0000
`define RLPR_PORT_RST      32'h0000_0000
`define RLPR_SELF_RST      32'h0000_0001

`define RLPR_CLK_MHZ       200
`define RLPR_LISTEN_MS     100
`define RLPR_PER_HALF_MS   500
`define RLPR_PER_ONE_MS    1000
`define RLPR_PER_FOUR_MS   4000
`define RLPR_HDR_HALF_MS   700
`define RLPR_HDR_ONE_MS    1200
`define RLPR_HDR_FOUR_MS   4200
`define RLPR_ACK_WAIT_MS   20
`define RLPR_MS_CYC        (`RLPR_CLK_MHZ * 1000)

`endif

// File: design/rlpr_pkg.sv
// Types shared by the link controller
package rlpr_pkg;
   typedef enum logic [1:0] {PM_ALWAYS, PM_HALF, PM_ONE, PM_FOUR} rlpr_pmode_t;
   typedef enum logic [1:0] {PR_TRANSP, PR_AWARE, PR_NODE, PR_SPARE} rlpr_proto_t;
   typedef enum logic [1:0] {RL_NONE, RL_LOW, RL_MED, RL_HIGH} rlpr_retry_t;
   typedef enum logic [2:0] {IF_SYNCDEV, IF_RS232, IF_USB, IF_ROUTER, IF_MEMASTER,
                             IF_SP5, IF_SP6, IF_SP7} rlpr_iface_t;
   typedef enum {S_IDLE, S_HDR, S_TX, S_ACKW, S_BACK} rlpr_state_t;

   typedef struct packed {
      logic [11:0] dest;
      logic [19:0] data;
   } rlpr_txreq_t;

   typedef struct packed {
      logic [11:0] src;
      logic [11:0] dest;
      logic [19:0] data;
   } rlpr_rfpkt_t;
endpackage

// File: design/rlpr_ctrl.sv
// Radio link controller: power duty cycle, wakeup header, acknowledged delivery with retries
// Contract
// - Half-second mode: receiver listens 100 ms every 0.5 s.
// - Half-second mode: first send after RF silence gets a 700 ms header.
// - One-second mode: receiver listens 100 ms every second.
// - One-second mode: first send after RF silence gets a 1.2 s header.
// - Four-second mode: receiver listens 100 ms every four seconds.
// - Four-second mode: first send after RF silence gets a 4.2 s header.
// - Unacknowledged packet is resent after a random delay.
// - Valid-CRC packet addressed to us is answered with an acknowledgement.
// - Retry level sets resends: none 0, low 3, medium 5, high 7.
// - Transparent mode forwards data uninterpreted; foreign protocols need retry none.
// - Protocol-aware mode takes the attached equipment address as RF identifier.
// - Acks and retries only in protocol-aware and addressable-node modes; the code also enables them in the spare protocol setting.
// - Transmit power selects 7, 15, 18, 21 or 24 dBm.
// - Sync device address applies only while that port mode is active.
// - Baud setting applies to the RS-232 port only while it is selected.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "rlpr_defines.svh"

module rlpr_fifo
   import rlpr_pkg::*;
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
)(
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     in_valid,
   output logic                          in_ready,
   input  wire logic [WIDTH-1:0]         in_data,
   output logic                          out_valid,
   input  wire logic                     out_ready,
   output logic [WIDTH-1:0]              out_data,
   output logic [$clog2(DEPTH):0]        level
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("rlpr_fifo: DEPTH must be a power of two");
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0]      wp_r;
   logic [AW:0]      rp_r;
   logic [AW:0]      wp_nxt;
   logic [AW:0]      rp_nxt;
   always_comb
   begin
      in_ready  = (wp_r - rp_r) != (AW+1)'(DEPTH);
      out_valid = wp_r != rp_r;
      out_data  = mem_r[rp_r[AW-1:0]];
      level     = wp_r - rp_r;
      wp_nxt    = wp_r + (AW+1)'(in_valid && in_ready);
      rp_nxt    = rp_r + (AW+1)'(out_valid && out_ready);
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wp_r <= '0;
         rp_r <= '0;
      end
      else
      begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
   end
   always_ff @(posedge pclk)
   begin
      if (in_valid && in_ready)
         mem_r[wp_r[AW-1:0]] <= in_data;
   end
endmodule // rlpr_fifo

module rlpr_ctrl
   import rlpr_pkg::*;
#(
   parameter int MS_CYC     = `RLPR_MS_CYC,
   parameter int FIFO_DEPTH = 32
)(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic [7:0]        paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [11:0]       attached_addr,
   input  wire logic              rf_activity,
   output logic                   rf_tx_valid,
   input  wire logic              rf_tx_ready,
   output rlpr_rfpkt_t            rf_tx_pkt,
   output logic                   rf_wake_hdr,
   output logic                   rf_ack_valid,
   output rlpr_rfpkt_t            rf_ack_pkt,
   input  wire logic              rf_rx_valid,
   input  wire rlpr_rfpkt_t       rf_rx_pkt,
   input  wire logic              rf_rx_crc_ok,
   input  wire logic              rf_rx_is_ack,
   output logic                   rx_out_valid,
   output rlpr_rfpkt_t            rx_out_pkt,
   output logic                   rx_pwr_on,
   output logic [4:0]             tx_dbm,
   output logic [14:0]            rf_network_identifier,
   output logic [3:0]             channel_hop_order,
   output logic                   sync_device_port_mode,
   output logic [3:0]             sync_dev_addr,
   output logic                   rs232_sel,
   output logic [3:0]             rs232_baud
);
   if (MS_CYC < 2)
      $error("rlpr_ctrl: MS_CYC must be at least 2");
   localparam int PW = $clog2(MS_CYC);

   function automatic logic [12:0] period_ms(input rlpr_pmode_t m);
      unique case (m)
         PM_ALWAYS: period_ms = 13'd1;
         PM_HALF:   period_ms = 13'(`RLPR_PER_HALF_MS);
         PM_ONE:    period_ms = 13'(`RLPR_PER_ONE_MS);
         PM_FOUR:   period_ms = 13'(`RLPR_PER_FOUR_MS);
      endcase
   endfunction
   function automatic logic [12:0] hdr_ms(input rlpr_pmode_t m);
      unique case (m)
         PM_ALWAYS: hdr_ms = 13'd0;
         PM_HALF:   hdr_ms = 13'(`RLPR_HDR_HALF_MS);
         PM_ONE:    hdr_ms = 13'(`RLPR_HDR_ONE_MS);
         PM_FOUR:   hdr_ms = 13'(`RLPR_HDR_FOUR_MS);
      endcase
   endfunction
   function automatic logic [2:0] max_retry(input rlpr_retry_t l);
      unique case (l)
         RL_NONE: max_retry = 3'd0;
         RL_LOW:  max_retry = 3'd3;
         RL_MED:  max_retry = 3'd5;
         RL_HIGH: max_retry = 3'd7;
      endcase
   endfunction
   function automatic logic [4:0] dbm_of(input logic [2:0] s);
      case (s)
         3'h0:    dbm_of = 5'd7;
         3'h1:    dbm_of = 5'd15;
         3'h2:    dbm_of = 5'd18;
         3'h3:    dbm_of = 5'd21;
         default: dbm_of = 5'd24;
      endcase
   endfunction

   // Register bus
   logic [31:0]     ctrl_r, ctrl_nxt, net_r, net_nxt, port_r, port_nxt, self_r, self_nxt;
   logic [31:0]     prdata_r, prdata_nxt;
   logic            wr_acc, push, mapped;
   rlpr_state_t     state_r, state_nxt;
   logic [2:0]      retry_r, retry_nxt;
   logic [7:0]      drop_r, drop_nxt;
   logic            fifo_in_ready, fifo_out_valid, fifo_out_ready;
   rlpr_txreq_t     fifo_out;
   logic [$clog2(FIFO_DEPTH):0] fifo_level;
   logic            rx_pwr_r, rx_pwr_nxt;

   rlpr_pmode_t     pmode;
   rlpr_proto_t     proto;
   rlpr_retry_t     rlevel;
   rlpr_iface_t     iface;
   logic            acks_on;
   logic [11:0]     my_id;

   always_comb
   begin
      pmode   = rlpr_pmode_t'(ctrl_r[`RLPR_PMODE_LSB +: 2]);
      proto   = rlpr_proto_t'(ctrl_r[`RLPR_PROTO_LSB +: 2]);
      rlevel  = rlpr_retry_t'(ctrl_r[`RLPR_RETRY_LSB +: 2]);
      iface   = rlpr_iface_t'(ctrl_r[`RLPR_IFACE_LSB +: 3]);
      acks_on = proto != PR_TRANSP;
      my_id   = (proto == PR_AWARE) ? attached_addr : self_r[11:0];
   end

   always_comb
   begin
      mapped  = paddr inside {`RLPR_OFF_CTRL, `RLPR_OFF_NET, `RLPR_OFF_PORT, `RLPR_OFF_SELF,
                              `RLPR_OFF_STAT, `RLPR_OFF_TXD, `RLPR_OFF_LVL};
      push    = psel && penable && pwrite && paddr == `RLPR_OFF_TXD;
      pready  = !(push && !fifo_in_ready);
      pslverr = psel && penable && !mapped;
      wr_acc  = psel && penable && pwrite && pready;
      prdata  = prdata_r;
      ctrl_nxt = ctrl_r;
      net_nxt  = net_r;
      port_nxt = port_r;
      self_nxt = self_r;
      prdata_nxt = prdata_r;
      if (wr_acc)
      begin
         unique case (paddr)
            `RLPR_OFF_CTRL: ctrl_nxt = {20'h0, pwdata[11:0]};
            `RLPR_OFF_NET:  net_nxt  = {12'h0, pwdata[19:16], 1'b0, pwdata[14:0]};
            `RLPR_OFF_PORT: port_nxt = {24'h0, pwdata[7:0]};
            `RLPR_OFF_SELF: self_nxt = {20'h0, pwdata[11:0]};
            default: ;
         endcase
      end
      if (psel && !penable && !pwrite)
      begin
         unique case (paddr)
            `RLPR_OFF_CTRL: prdata_nxt = ctrl_r;
            `RLPR_OFF_NET:  prdata_nxt = net_r;
            `RLPR_OFF_PORT: prdata_nxt = port_r;
            `RLPR_OFF_SELF: prdata_nxt = self_r;
            `RLPR_OFF_STAT: prdata_nxt = {16'h0, drop_r, 1'b0, retry_r, 1'b0,
                                          state_r == S_ACKW, state_r == S_HDR, rx_pwr_r};
            `RLPR_OFF_LVL:  prdata_nxt = 32'(fifo_level);
            default:        prdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r   <= `RLPR_CTRL_RST;
         net_r    <= `RLPR_NET_RST;
         port_r   <= `RLPR_PORT_RST;
         self_r   <= `RLPR_SELF_RST;
         prdata_r <= 32'h0000_0000;
      end
      else
      begin
         ctrl_r   <= ctrl_nxt;
         net_r    <= net_nxt;
         port_r   <= port_nxt;
         self_r   <= self_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // Settings steered to the radio and the serial ports
   always_comb
   begin
      tx_dbm                = dbm_of(ctrl_r[`RLPR_TXPWR_LSB +: 3]);
      rf_network_identifier = net_r[`RLPR_NETID_LSB +: 15];
      channel_hop_order     = net_r[`RLPR_HOP_LSB +: 4];
      sync_device_port_mode = iface == IF_SYNCDEV;
      sync_dev_addr = sync_device_port_mode ? port_r[`RLPR_SDADDR_LSB +: 4] : 4'h0;
      rs232_sel     = iface == IF_RS232;
      rs232_baud    = rs232_sel ? port_r[`RLPR_BAUD_LSB +: 4] : 4'h0;
   end

   rlpr_fifo #(.WIDTH($bits(rlpr_txreq_t)), .DEPTH(FIFO_DEPTH)) u_txq (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   (pwdata),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out),
      .level     (fifo_level)
   );

   // Link engine
   logic [PW-1:0]   pre_r, pre_nxt;
   logic            tick;
   logic [12:0]     phase_r, phase_nxt, idle_r, idle_nxt, cnt_r, cnt_nxt;
   logic [15:0]     lfsr_r, lfsr_nxt;
   rlpr_rfpkt_t     cur_r, cur_nxt, ack_pkt_r, ack_pkt_nxt, rx_pkt_r, rx_pkt_nxt;
   logic            ack_v_r, ack_v_nxt, rx_v_r, rx_v_nxt, quiet, ack_hit, for_me;

   always_comb
   begin
      tick      = pre_r == PW'(MS_CYC - 1);
      pre_nxt   = tick ? '0 : pre_r + 1'b1;
      lfsr_nxt  = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      phase_nxt = phase_r;
      if (pmode == PM_ALWAYS)
         phase_nxt = 13'd0;
      else if (tick)
         phase_nxt = (phase_r + 13'd1 >= period_ms(pmode)) ? 13'd0 : phase_r + 13'd1;
      quiet    = idle_r >= period_ms(pmode);
      idle_nxt = idle_r;
      if (rf_activity || rf_rx_valid || state_r inside {S_HDR, S_TX})
         idle_nxt = 13'd0;
      else if (tick && idle_r != 13'h1FFF)
         idle_nxt = idle_r + 13'd1;
      // Receiver on through the listen window and while a reply is due
      rx_pwr_nxt = pmode == PM_ALWAYS
                || phase_r < 13'(`RLPR_LISTEN_MS)
                || state_r == S_ACKW;
      for_me  = rf_rx_valid && rf_rx_crc_ok && rf_rx_pkt.dest == my_id;
      ack_hit = for_me && rf_rx_is_ack && rf_rx_pkt.src == cur_r.dest;
      ack_v_nxt   = for_me && !rf_rx_is_ack && acks_on;
      ack_pkt_nxt = ack_pkt_r;
      if (ack_v_nxt)
         ack_pkt_nxt = '{src: my_id, dest: rf_rx_pkt.src, data: 20'h0};
      // Transparent mode passes every frame through untouched
      rx_v_nxt   = acks_on ? (for_me && !rf_rx_is_ack) : rf_rx_valid;
      rx_pkt_nxt = rf_rx_valid ? rf_rx_pkt : rx_pkt_r;
      fifo_out_ready = state_r == S_IDLE;
      state_nxt = state_r;
      cur_nxt   = cur_r;
      cnt_nxt   = (tick && cnt_r != 13'd0) ? cnt_r - 13'd1 : cnt_r;
      retry_nxt = retry_r;
      drop_nxt  = drop_r;
      unique case (state_r)
         S_IDLE:
            if (fifo_out_valid)
            begin
               cur_nxt   = '{src: my_id, dest: fifo_out.dest, data: fifo_out.data};
               retry_nxt = 3'd0;
               if (pmode != PM_ALWAYS && quiet)
               begin
                  state_nxt = S_HDR;
                  cnt_nxt   = hdr_ms(pmode);
               end
               else
                  state_nxt = S_TX;
            end
         S_HDR:
            if (tick && cnt_r == 13'd0)
               state_nxt = S_TX;
         S_TX:
            if (rf_tx_ready)
            begin
               if (acks_on)
               begin
                  state_nxt = S_ACKW;
                  cnt_nxt   = 13'(`RLPR_ACK_WAIT_MS);
               end
               else
                  state_nxt = S_IDLE;
            end
         S_ACKW:
            if (ack_hit)
               state_nxt = S_IDLE;
            else if (tick && cnt_r == 13'd0)
            begin
               if (retry_r < max_retry(rlevel))
               begin
                  state_nxt = S_BACK;
                  retry_nxt = retry_r + 3'd1;
                  cnt_nxt   = {8'h0, lfsr_r[4:0]} + 13'd1;
               end
               else
               begin
                  state_nxt = S_IDLE;
                  drop_nxt  = drop_r + 8'd1;
               end
            end
         S_BACK:
            if (tick && cnt_r == 13'd0)
               state_nxt = S_TX;
      endcase
      rf_tx_valid  = state_r == S_TX;
      rf_tx_pkt    = cur_r;
      rf_wake_hdr  = state_r == S_HDR;
      rf_ack_valid = ack_v_r;
      rf_ack_pkt   = ack_pkt_r;
      rx_out_valid = rx_v_r;
      rx_out_pkt   = rx_pkt_r;
      rx_pwr_on    = rx_pwr_r;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pre_r     <= '0;
         phase_r   <= 13'd0;
         idle_r    <= 13'h1FFF;
         cnt_r     <= 13'd0;
         lfsr_r    <= 16'hACE1;
         state_r   <= S_IDLE;
         cur_r     <= '0;
         retry_r   <= 3'd0;
         drop_r    <= 8'h00;
         ack_v_r   <= 1'b0;
         ack_pkt_r <= '0;
         rx_v_r    <= 1'b0;
         rx_pkt_r  <= '0;
         rx_pwr_r  <= 1'b1;
      end
      else
      begin
         pre_r     <= pre_nxt;
         phase_r   <= phase_nxt;
         idle_r    <= idle_nxt;
         cnt_r     <= cnt_nxt;
         lfsr_r    <= lfsr_nxt;
         state_r   <= state_nxt;
         cur_r     <= cur_nxt;
         retry_r   <= retry_nxt;
         drop_r    <= drop_nxt;
         ack_v_r   <= ack_v_nxt;
         ack_pkt_r <= ack_pkt_nxt;
         rx_v_r    <= rx_v_nxt;
         rx_pkt_r  <= rx_pkt_nxt;
         rx_pwr_r  <= rx_pwr_nxt;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_always_rx;
      pmode == PM_ALWAYS |=> rx_pwr_on || $past(pmode) != PM_ALWAYS;
   endproperty
   a_always_rx: assert property (p_always_rx) else $error("rx off in always-on");
   property p_no_hdr_always;
      state_r == S_IDLE && state_nxt == S_HDR |-> pmode != PM_ALWAYS && quiet;
   endproperty
   a_no_hdr_always: assert property (p_no_hdr_always) else $error("bad header");
   property p_listen;
      phase_r < 13'(`RLPR_LISTEN_MS) |=> rx_pwr_on;
   endproperty
   a_listen: assert property (p_listen) else $error("rx off in window");
   property p_hdr_len;
      $rose(rf_wake_hdr) |-> cnt_r == hdr_ms($past(pmode));
   endproperty
   a_hdr_len: assert property (p_hdr_len) else $error("wrong header length");
   property p_backoff;
      state_r == S_ACKW && !ack_hit && tick && cnt_r == 13'd0 && retry_r < max_retry(rlevel)
         |=> state_r == S_BACK && cnt_r >= 13'd1 && cnt_r <= 13'd32;
   endproperty
   a_backoff: assert property (p_backoff) else $error("no backoff");
   property p_ack_back;
      rf_rx_valid && rf_rx_crc_ok && !rf_rx_is_ack && rf_rx_pkt.dest == my_id && acks_on
         |=> rf_ack_valid && rf_ack_pkt.dest == $past(rf_rx_pkt.src);
   endproperty
   a_ack_back: assert property (p_ack_back) else $error("ack missing");
   // A level lowered by software mid-packet may leave a stale count; only growth is checked
   property p_retry_cap;
      $stable(rlevel) && $past(retry_r) <= max_retry(rlevel) |-> retry_r <= max_retry(rlevel);
   endproperty
   a_retry_cap: assert property (p_retry_cap) else $error("retries exceeded");
   property p_transp;
      !acks_on && rf_rx_valid |=> rx_out_valid && !rf_ack_valid;
   endproperty
   a_transp: assert property (p_transp) else $error("transparent frame lost");
   property p_own_id;
      proto == PR_AWARE && state_r == S_IDLE && fifo_out_valid |=> rf_tx_pkt.src == $past(attached_addr);
   endproperty
   a_own_id: assert property (p_own_id) else $error("wrong RF identifier");
   property p_dbm;
      tx_dbm inside {5'd7, 5'd15, 5'd18, 5'd21, 5'd24};
   endproperty
   a_dbm: assert property (p_dbm) else $error("bad tx level");
   property p_port_gate;
      (!sync_device_port_mode |-> sync_dev_addr == 4'h0) and (!rs232_sel |-> rs232_baud == 4'h0);
   endproperty
   a_port_gate: assert property (p_port_gate) else $error("port setting leaked");

   c_header:  cover property (state_r == S_HDR ##1 state_r == S_TX);
   c_retry:   cover property (state_r == S_BACK ##1 state_r == S_TX);
   c_drop:    cover property ($changed(drop_r));
   c_acked:   cover property (state_r == S_ACKW && ack_hit);
endmodule // rlpr_ctrl

`default_nettype wire

// File: verification/rlpr_peer.sv
// Peer radio model: accepts frames, may acknowledge them, injects received frames
`timescale 1ns/1ps
`default_nettype none
module rlpr_peer
   import rlpr_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        stall,
   input  wire logic        ack_en,
   input  wire logic        inj,
   input  wire rlpr_rfpkt_t inj_pkt,
   input  wire logic        inj_crc,
   input  wire logic        tx_valid,
   input  wire rlpr_rfpkt_t tx_pkt,
   output logic             tx_ready,
   output logic             rx_valid,
   output rlpr_rfpkt_t      rx_pkt,
   output logic             rx_crc,
   output logic             rx_ack,
   output int               tx_cnt
);
   logic [2:0]  dly;
   rlpr_rfpkt_t ack_pkt;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_ready <= 1'b0;
         rx_valid <= 1'b0;
         rx_pkt   <= '0;
         rx_crc   <= 1'b0;
         rx_ack   <= 1'b0;
         tx_cnt   <= 0;
         dly      <= '0;
      end
      else
      begin
         // Ready comes a cycle late and never while stalled
         tx_ready <= tx_valid && !tx_ready && !stall;
         rx_valid <= 1'b0;
         // Idle line inverts every bit of the frame it last showed, each cycle
         rx_pkt   <= ~rx_pkt;
         dly      <= dly << 1;
         if (tx_valid && tx_ready)
         begin
            tx_cnt  <= tx_cnt + 1;
            dly     <= {2'b00, ack_en};
            ack_pkt <= '{src: tx_pkt.dest, dest: tx_pkt.src, data: '0};
         end
         if (dly[2])
         begin
            rx_valid <= 1'b1;
            rx_pkt   <= ack_pkt;
            rx_crc   <= 1'b1;
            rx_ack   <= 1'b1;
         end
         else if (inj)
         begin
            rx_valid <= 1'b1;
            rx_pkt   <= inj_pkt;
            rx_crc   <= inj_crc;
            rx_ack   <= 1'b0;
         end
      end
   end
endmodule // rlpr_peer
`default_nettype wire

// File: verification/radio_link_power_retry_ctrl_tb_top.sv
// Self-checking bench of the radio link controller
`timescale 1ns/1ps
`default_nettype none
`include "rlpr_defines.svh"
module radio_link_power_retry_ctrl_tb_top;
   import rlpr_pkg::*;
   localparam int MS = 10;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [7:0]  paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic        pready, pslverr, rf_activity = 0, rf_tx_valid, rf_tx_ready;
   logic        rf_wake_hdr, rf_ack_valid, rf_rx_valid, rf_rx_crc_ok, rf_rx_is_ack;
   logic        rx_out_valid, rx_pwr_on, sync_device_port_mode, rs232_sel;
   logic        stall = 0, ack_en = 0, inj = 0, inj_crc = 0;
   logic [11:0] attached_addr = 12'h0AB, last_src;
   logic [4:0]  tx_dbm;
   logic [14:0] rf_network_identifier;
   logic [3:0]  channel_hop_order, sync_dev_addr, rs232_baud;
   rlpr_rfpkt_t rf_tx_pkt, rf_ack_pkt, rf_rx_pkt, rx_out_pkt, inj_pkt = '0;
   int          mismatches = 0, cmp_count = 0, tx_cnt, n, t0, hdr_n = 0;
   int          rc[4] = '{0, 3, 5, 7};
   int          db[5] = '{7, 15, 18, 21, 24};
   int          hd[3] = '{0, `RLPR_HDR_HALF_MS * MS, `RLPR_HDR_ONE_MS * MS};
   rlpr_ctrl #(.MS_CYC(MS), .FIFO_DEPTH(32)) i_dut (
      .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .attached_addr, .rf_activity, .rf_tx_valid, .rf_tx_ready, .rf_tx_pkt,
      .rf_wake_hdr, .rf_ack_valid, .rf_ack_pkt, .rf_rx_valid, .rf_rx_pkt,
      .rf_rx_crc_ok, .rf_rx_is_ack, .rx_out_valid, .rx_out_pkt, .rx_pwr_on, .tx_dbm,
      .rf_network_identifier, .channel_hop_order, .sync_device_port_mode,
      .sync_dev_addr, .rs232_sel, .rs232_baud);
   rlpr_peer i_peer (.pclk, .presetn, .stall, .ack_en, .inj, .inj_pkt, .inj_crc,
      .tx_valid(rf_tx_valid), .tx_pkt(rf_tx_pkt), .tx_ready(rf_tx_ready),
      .rx_valid(rf_rx_valid), .rx_pkt(rf_rx_pkt), .rx_crc(rf_rx_crc_ok),
      .rx_ack(rf_rx_is_ack), .tx_cnt);
   initial forever #2.5 pclk = ~pclk;
   always @(negedge pclk)
   begin
      if (rf_wake_hdr === 1'b1) hdr_n++;
      if (rf_tx_valid === 1'b1 && rf_tx_ready === 1'b1) last_src = rf_tx_pkt.src;
   end
   task automatic wrap_up();
      if (mismatches == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // Request holds until pready is seen high at a rising edge; data taken there
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic ctl(input int pm, input int pr, input int rl, input int pw, input int ifc);
      apb(1, `RLPR_OFF_CTRL, 32'(pm + 4 * pr + 16 * rl + 64 * pw + 512 * ifc));
      @(negedge pclk);
   endtask
   task automatic rxf(input logic [11:0] dst, input logic c, input logic [1:0] exp);
      logic [1:0] seen;
      seen = '0;
      @(posedge pclk);
      inj_pkt <= '{src: 12'h022, dest: dst, data: 20'h5A5A5};
      inj_crc <= c;
      inj <= 1'b1;
      @(posedge pclk);
      inj <= 1'b0;
      repeat (4)
      begin
         @(negedge pclk);
         seen |= {rf_ack_valid === 1'b1, rx_out_valid === 1'b1};
         if (rf_ack_valid === 1'b1)
            chk(32'({rf_ack_pkt.src, rf_ack_pkt.dest}), 32'h001022, "ack pkt");
         if (rx_out_valid === 1'b1)
            chk(32'(rx_out_pkt.data), 32'h5A5A5, "fwd pkt");
      end
      chk(32'(seen), 32'(exp), "ack fwd");
   endtask
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      chk(32'({tx_dbm, rx_pwr_on}), 32'h31, "rst out");
      apb(0, `RLPR_OFF_CTRL, 0);
      chk(rd, `RLPR_CTRL_RST, "ctrl");
      apb(0, `RLPR_OFF_SELF, 0);
      chk(rd, `RLPR_SELF_RST, "self");
      apb(0, 8'h1C, 0);
      chk({err, rd[30:0]}, 32'h8000_0000, "unmapped");
      apb(1, `RLPR_OFF_NET, 32'h0005_7FFF);
      @(negedge pclk);
      chk(32'({channel_hop_order, rf_network_identifier}), 32'h2FFFF, "net");
      apb(1, `RLPR_OFF_PORT, 32'h0000_0035);
      for (int i = 0; i < 5; i++)
      begin
         ctl(0, 2, 0, i, i);
         chk(32'({sync_device_port_mode, sync_dev_addr, rs232_sel, rs232_baud}),
             (i == 0) ? 32'h2A0 : (i == 1) ? 32'h013 : 32'h0, "port");
         chk(32'(tx_dbm), 32'(db[i]), "dbm");
      end
      rxf(12'h001, 1'b1, 2'b11);
      rxf(12'h001, 1'b0, 2'b00);
      rxf(12'h005, 1'b1, 2'b00);
      ctl(0, 0, 0, 4, 2);
      rxf(12'h001, 1'b1, 2'b01);
      for (int lv = 0; lv < 4; lv++)
      begin
         ctl(0, 2, lv, 4, 2);
         apb(0, `RLPR_OFF_STAT, 0);
         t0 = rd[15:8];
         n = tx_cnt;
         apb(1, `RLPR_OFF_TXD, 32'h0050_0001);
         repeat (6000) @(posedge pclk);
         chk(32'(tx_cnt - n), 32'(1 + rc[lv]), "sends");
         apb(0, `RLPR_OFF_STAT, 0);
         chk(32'(rd[15:8]), 32'((t0 + 1) % 256), "drop");
      end
      ack_en <= 1'b1;
      for (int pr = 0; pr < 2; pr++)
      begin
         ctl(0, pr, 3, 4, 2);
         n = tx_cnt;
         apb(1, `RLPR_OFF_TXD, 32'h0050_0002);
         repeat (600) @(posedge pclk);
         chk(32'(tx_cnt - n), 1, "one send");
      end
      chk(32'(last_src), 32'h0AB, "aware id");
      ack_en <= 1'b0;
      ctl(0, 0, 0, 4, 2);
      stall <= 1'b1;
      n = tx_cnt;
      repeat (33) apb(1, `RLPR_OFF_TXD, 32'h0050_0003);
      apb(0, `RLPR_OFF_LVL, 0);
      chk(rd, 32, "full");
      fork
         apb(1, `RLPR_OFF_TXD, 32'h0050_0004);
         begin
            repeat (8) @(posedge pclk);
            chk(32'(pready), 0, "refuse");
            stall <= 1'b0;
         end
      join
      repeat (300) @(posedge pclk);
      apb(0, `RLPR_OFF_LVL, 0);
      chk(rd, 0, "empty");
      chk(32'(tx_cnt - n), 34, "drained");
      chk(32'(hdr_n), 0, "no hdr");
      for (int m = 1; m < 3; m++)
      begin
         ctl(m, 0, 0, 4, 2);
         repeat (m * `RLPR_PER_HALF_MS * MS) @(posedge pclk);
         n = 0;
         repeat (m * `RLPR_PER_HALF_MS * MS) @(negedge pclk) n += (rx_pwr_on === 1'b1);
         chk(32'(n), 32'(`RLPR_LISTEN_MS * MS), "listen");
         for (int k = 0; k < 2; k++)
         begin
            apb(1, `RLPR_OFF_TXD, 32'h0050_0005);
            t0 = 0;
            while (rf_tx_valid !== 1'b1 && t0 < 50000)
            begin
               @(negedge pclk);
               t0++;
            end
            chk(32'(t0 >= hd[m] * (1 - k) && t0 <= hd[m] * (1 - k) + 14), 1, "hdr");
            repeat (4) @(posedge pclk);
         end
      end
      wrap_up();
   end
   initial
   begin
      #495000;
      mismatches++;
      wrap_up();
   end
endmodule // radio_link_power_retry_ctrl_tb_top
`default_nettype wire
